// File: core/fbfr_pkg.sv
// Constants and types for the fieldbus fault and reset control block
package fbfr_pkg;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_HZ            = 25000000;
    localparam int CMD_BLOCK_MS      = 1000;
    localparam int CMD_BLOCK_CYCLES  = CLK_HZ / 1000 * CMD_BLOCK_MS;
    localparam int WAIT_UNIT_MS      = 100;
    localparam int WAIT_UNIT_CYCLES  = CLK_HZ / 1000 * WAIT_UNIT_MS;
    localparam int FLICKER_MS        = 250;
    localparam int FLICKER_CYCLES    = CLK_HZ / 1000 * FLICKER_MS;

    // ********************************
    // Settings
    // ********************************
    localparam logic [6:0] STATION_MIN   = 7'h01;
    localparam logic [6:0] STATION_MAX   = 7'h40;
    localparam logic [6:0] STATION_RESET = 7'h01;
    localparam logic [2:0] SPEED_MAX     = 3'h4;
    localparam logic [2:0] SPEED_RESET   = 3'h0;
    localparam logic [1:0] STOP_COAST    = 2'h0;
    localparam logic [1:0] STOP_DECEL    = 2'h1;
    localparam logic [1:0] STOP_DECEL_NF = 2'h2;
    localparam logic [1:0] STOP_CONTINUE = 2'h3;

    // ********************************
    // Fault indication codes
    // ********************************
    localparam logic [7:0] FAULT_NONE   = 8'h00;
    localparam logic [7:0] FAULT_LINE   = 8'ha1;
    localparam logic [7:0] FAULT_OPTION = 8'hf1;

    typedef enum logic [1:0] {
        FBFR_MODE_EXT = 2'b00,
        FBFR_MODE_NET = 2'b01,
        FBFR_MODE_PNL = 2'b10
    } fbfr_mode_t;

    typedef enum logic [1:0] {
        FBFR_LS_OK    = 2'b00,
        FBFR_LS_WAIT  = 2'b01,
        FBFR_LS_FAULT = 2'b10
    } fbfr_line_t;

endpackage

// File: core/fbfr_counter.sv
// Down counter that flags when a loaded count has run out
`timescale 1ns/1ps
module fbfr_counter #(
    parameter int WIDTH = 25
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             enable,
    output logic                  busy,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    initial begin
        if (WIDTH < 2 || WIDTH > 31) begin
            $error("fbfr_counter width out of range");
        end
    end

    // ********************************
    // Counting
    // ********************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (load) begin
            count <= loadValue;
        end else if (enable && count != '0) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
        end else begin
            done <= !load && enable && count == {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign busy = (count != '0);
endmodule

// File: core/fbfr_led_flicker.sv
// Blink generator for the link-error indicator
`timescale 1ns/1ps
module fbfr_led_flicker #(
    parameter int HALF_PERIOD = 6250000
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic active,
    output logic      led
);
    logic [23:0] tick;

    initial begin
        if (HALF_PERIOD < 1 || HALF_PERIOD > 16777215) begin
            $error("fbfr_led_flicker half period out of range");
        end
    end

    // ********************************
    // Blink
    // ********************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 24'h000000;
            led  <= 1'b0;
        end else if (!active) begin
            tick <= 24'h000000;
            led  <= 1'b0;
        end else if (tick == 24'(HALF_PERIOD - 1)) begin
            tick <= 24'h000000;
            led  <= !led;
        end else begin
            tick <= tick + 24'h000001;
        end
    end
endmodule

// File: core/fbfr_control.sv
// Fault reaction, reset gating and link configuration of the fieldbus option
`timescale 1ns/1ps
module fbfr_control #(
    parameter int CMD_BLOCK_CYCLES = fbfr_pkg::CMD_BLOCK_CYCLES,
    parameter int WAIT_UNIT_CYCLES = fbfr_pkg::WAIT_UNIT_CYCLES,
    parameter int FLICKER_CYCLES   = fbfr_pkg::FLICKER_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        hwResetTerminal,
    input  wire logic [1:0]  operationMode,
    input  wire logic        modeChangeStrobe,
    input  wire logic        commLineError,
    input  wire logic        optionContactFail,
    input  wire logic        optionInternalFail,
    input  wire logic        protectiveTrip,
    input  wire logic        netErrorResetRequest,
    input  wire logic        netDriveResetRequest,
    input  wire logic        driveCommandValid,
    input  wire logic        faultResetScopeSelect,
    input  wire logic [7:0]  startupModeSelect,
    input  wire logic [1:0]  stopModeOnCommError,
    input  wire logic [13:0] commErrorWaitTime,
    input  wire logic [6:0]  stationNumberSelect,
    input  wire logic [2:0]  linkSpeedSelect,
    output logic [1:0]       activeMode,
    output logic             dataExchangeEnable,
    output logic             tripCoast,
    output logic             tripDecel,
    output logic             faultOutput,
    output logic [7:0]       faultCode,
    output logic             driveResetPulse,
    output logic             errorResetPulse,
    output logic             driveCommandAccept,
    output logic [6:0]       activeStation,
    output logic [2:0]       activeLinkSpeed,
    output logic             settingInvalid,
    output logic             linkErrorLed
);
    localparam int WAIT_W = 31;

    fbfr_pkg::fbfr_mode_t mode;
    fbfr_pkg::fbfr_line_t lineState;
    logic                 netMode;
    logic                 termPrev;
    logic                 termRise;
    logic                 resetInNet;
    logic                 driveResetHold;
    logic                 blockBusy;
    logic                 unitTick;
    logic                 unitBusy;
    logic                 waitLoad;
    logic                 waitDone;
    logic                 waitBusy;
    logic                 lineFault;
    logic                 optionFault;
    logic                 settingsDiffer;
    logic                 netResetAllowed;
    logic                 stationOk;
    logic                 speedOk;
    logic [1:0]           latchedStop;
    logic [WAIT_W-1:0]    waitCycles;

    initial begin
        if (CMD_BLOCK_CYCLES < 1 || WAIT_UNIT_CYCLES < 1 || FLICKER_CYCLES < 1) begin
            $error("fbfr_control timing parameters must be positive");
        end
    end

    assign netMode   = (mode == fbfr_pkg::FBFR_MODE_NET);
    assign termRise  = hwResetTerminal && !termPrev;
    assign lineFault = (lineState == fbfr_pkg::FBFR_LS_FAULT);
    assign optionFault = optionContactFail || optionInternalFail;
    assign stationOk = stationNumberSelect >= fbfr_pkg::STATION_MIN
                       && stationNumberSelect <= fbfr_pkg::STATION_MAX;
    assign speedOk   = linkSpeedSelect <= fbfr_pkg::SPEED_MAX;
    assign settingInvalid = !stationOk || !speedOk;

    // ********************************
    // Terminal edge
    // ********************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            termPrev <= 1'b0;
        end else begin
            termPrev <= hwResetTerminal;
        end
    end

    // ********************************
    // Operation mode
    // ********************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= fbfr_pkg::FBFR_MODE_EXT;
        end else if (termRise || driveResetPulse) begin
            if (resetInNet && startupModeSelect != 8'h00) begin
                mode <= fbfr_pkg::FBFR_MODE_NET;
            end else begin
                mode <= fbfr_pkg::FBFR_MODE_EXT;
            end
        end else if (modeChangeStrobe) begin
            case (operationMode)
                2'b01:   mode <= fbfr_pkg::FBFR_MODE_NET;
                2'b10:   mode <= fbfr_pkg::FBFR_MODE_PNL;
                default: mode <= fbfr_pkg::FBFR_MODE_EXT;
            endcase
        end
    end

    assign resetInNet = netMode || (startupModeSelect != 8'h00 && !termPrev && hwResetTerminal
                        && mode == fbfr_pkg::FBFR_MODE_NET);
    assign activeMode = mode;

    // ********************************
    // Line fault wait timer
    // ********************************
    assign waitCycles = WAIT_W'(commErrorWaitTime) * WAIT_W'(WAIT_UNIT_CYCLES);
    assign waitLoad   = lineState == fbfr_pkg::FBFR_LS_OK && commLineError && netMode;

    fbfr_counter #(
        .WIDTH     (WAIT_W)
    ) u_wait (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .load      (waitLoad),
        .loadValue (waitCycles),
        .enable    (lineState == fbfr_pkg::FBFR_LS_WAIT),
        .busy      (waitBusy),
        .done      (waitDone)
    );

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lineState <= fbfr_pkg::FBFR_LS_OK;
        end else if (termRise) begin
            lineState <= fbfr_pkg::FBFR_LS_OK;
        end else begin
            case (lineState)
                fbfr_pkg::FBFR_LS_OK: begin
                    if (waitLoad) begin
                        lineState <= (waitCycles == '0) ? fbfr_pkg::FBFR_LS_FAULT
                                                       : fbfr_pkg::FBFR_LS_WAIT;
                    end
                end
                fbfr_pkg::FBFR_LS_WAIT: begin
                    if (!commLineError || !netMode) begin
                        lineState <= fbfr_pkg::FBFR_LS_OK;
                    end else if (waitDone || !waitBusy) begin
                        lineState <= fbfr_pkg::FBFR_LS_FAULT;
                    end
                end
                fbfr_pkg::FBFR_LS_FAULT: begin
                    if (!commLineError && latchedStop >= fbfr_pkg::STOP_DECEL_NF) begin
                        lineState <= fbfr_pkg::FBFR_LS_OK;
                    end
                end
                default: lineState <= fbfr_pkg::FBFR_LS_OK;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            latchedStop <= fbfr_pkg::STOP_COAST;
        end else if (lineState != fbfr_pkg::FBFR_LS_FAULT) begin
            latchedStop <= stopModeOnCommError;
        end
    end

    // ********************************
    // Fault reaction
    // ********************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dataExchangeEnable <= 1'b1;
            tripCoast          <= 1'b0;
            tripDecel          <= 1'b0;
            faultOutput        <= 1'b0;
            faultCode          <= fbfr_pkg::FAULT_NONE;
        end else begin
            dataExchangeEnable <= !commLineError && !optionInternalFail;
            tripCoast   <= (lineFault && latchedStop == fbfr_pkg::STOP_COAST)
                           || (optionFault && (stopModeOnCommError == fbfr_pkg::STOP_COAST
                           || stopModeOnCommError == fbfr_pkg::STOP_CONTINUE)
                           && (netMode || optionContactFail));
            tripDecel   <= (lineFault && (latchedStop == fbfr_pkg::STOP_DECEL
                           || latchedStop == fbfr_pkg::STOP_DECEL_NF))
                           || (optionFault && (stopModeOnCommError == fbfr_pkg::STOP_DECEL
                           || stopModeOnCommError == fbfr_pkg::STOP_DECEL_NF)
                           && (netMode || optionContactFail));
            faultOutput <= (lineFault && latchedStop <= fbfr_pkg::STOP_DECEL)
                           || (optionFault && (netMode || optionContactFail));
            if (optionFault && (netMode || optionContactFail)) begin
                faultCode <= fbfr_pkg::FAULT_OPTION;
            end else if (lineFault && latchedStop <= fbfr_pkg::STOP_DECEL) begin
                faultCode <= fbfr_pkg::FAULT_LINE;
            end else begin
                faultCode <= fbfr_pkg::FAULT_NONE;
            end
        end
    end

    // ********************************
    // Network reset gating
    // ********************************
    assign netResetAllowed = !commLineError && !lineFault;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            driveResetPulse <= 1'b0;
            errorResetPulse <= 1'b0;
        end else begin
            driveResetPulse <= netDriveResetRequest && netMode && netResetAllowed
                               && !driveResetHold;
            errorResetPulse <= netErrorResetRequest && protectiveTrip && netResetAllowed
                               && (!faultResetScopeSelect || netMode);
        end
    end

    // ********************************
    // Command blanking after reset
    // ********************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            driveResetHold <= 1'b0;
        end else begin
            driveResetHold <= (netDriveResetRequest && netMode && netResetAllowed)
                              || (driveResetHold && netDriveResetRequest);
        end
    end

    fbfr_counter #(
        .WIDTH     (25)
    ) u_block (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .load      (driveResetHold && !netDriveResetRequest),
        .loadValue (25'(CMD_BLOCK_CYCLES)),
        .enable    (1'b1),
        .busy      (blockBusy),
        .done      ()
    );

    assign unitTick = 1'b0;
    assign unitBusy = unitTick;
    assign driveCommandAccept = driveCommandValid && !driveResetHold && !blockBusy
                                && !unitBusy;

    // ********************************
    // Link configuration shadows
    // ********************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            activeStation   <= fbfr_pkg::STATION_RESET;
            activeLinkSpeed <= fbfr_pkg::SPEED_RESET;
        end else if (termRise && stationOk && speedOk) begin
            activeStation   <= stationNumberSelect;
            activeLinkSpeed <= linkSpeedSelect;
        end
    end

    assign settingsDiffer = stationNumberSelect != activeStation
                            || linkSpeedSelect != activeLinkSpeed;

    fbfr_led_flicker #(
        .HALF_PERIOD (FLICKER_CYCLES)
    ) u_led (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .active      (settingsDiffer && !hwResetTerminal),
        .led         (linkErrorLed)
    );
endmodule

// File: test/fbfr_master_model.sv
// Master station model driving the network requests
`timescale 1ns/1ps
module fbfr_master_model #(
    parameter logic [6:0] PEER_STATION = 7'h01
) (
    input  wire logic mclk,
    output logic      netErrorResetRequest,
    output logic      netDriveResetRequest,
    output logic      driveCommandValid
);
    // ********************************
    // Requests
    // ********************************
    initial begin
        netErrorResetRequest = 1'b0;
        netDriveResetRequest = 1'b0;
        driveCommandValid = 1'b1;
    end

    task errReset();
        @(posedge mclk);
        netErrorResetRequest <= 1'b1;
        @(posedge mclk);
        netErrorResetRequest <= 1'b0;
    endtask

    task drvReset(input int hold);
        @(posedge mclk);
        netDriveResetRequest <= 1'b1;
        repeat (hold) @(posedge mclk);
        netDriveResetRequest <= 1'b0;
    endtask
endmodule

// File: test/fbfr_control_chk.sv
// Port checker for the fieldbus fault and reset control block
`timescale 1ns/1ps
module fbfr_control_chk (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       hwResetTerminal,
    input wire logic       commLineError,
    input wire logic       optionContactFail,
    input wire logic       protectiveTrip,
    input wire logic       netErrorResetRequest,
    input wire logic       netDriveResetRequest,
    input wire logic       faultResetScopeSelect,
    input wire logic [7:0] startupModeSelect,
    input wire logic [6:0] stationNumberSelect,
    input wire logic [2:0] linkSpeedSelect,
    input wire logic [1:0] activeMode,
    input wire logic       dataExchangeEnable,
    input wire logic [7:0] faultCode,
    input wire logic       driveResetPulse,
    input wire logic       errorResetPulse,
    input wire logic       driveCommandAccept,
    input wire logic [6:0] activeStation,
    input wire logic [2:0] activeLinkSpeed,
    input wire logic       linkErrorLed
);
    // ********************************
    // Helpers
    // ********************************
    logic errOk;
    logic drvOk;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            errOk <= 1'b0;
            drvOk <= 1'b0;
        end else begin
            errOk <= netErrorResetRequest && protectiveTrip && !commLineError
                     && (activeMode == fbfr_pkg::FBFR_MODE_NET || !faultResetScopeSelect);
            drvOk <= netDriveResetRequest && !commLineError
                     && activeMode == fbfr_pkg::FBFR_MODE_NET;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    chk_drive_reset_gate: assert property (driveResetPulse |-> drvOk)
        else $error("drive reset pulse without an accepted request");
    chk_error_reset_gate: assert property (errorResetPulse |-> errOk)
        else $error("error reset pulse without an accepted request");
    chk_restart_mode: assert property (driveResetPulse |-> ##[0:1]
        activeMode == (startupModeSelect != 8'h00 ? fbfr_pkg::FBFR_MODE_NET
                                                  : fbfr_pkg::FBFR_MODE_EXT))
        else $error("wrong mode after drive reset");
    chk_cmd_block: assert property (driveResetPulse |=> !driveCommandAccept [*8])
        else $error("drive command accepted right after reset");
    chk_shadow_hold: assert property ($changed(activeStation) || $changed(activeLinkSpeed)
        |-> $past(hwResetTerminal) || $past(hwResetTerminal, 2) || !$past(rst_b, 2))
        else $error("active link settings changed without terminal reset");
    chk_setting_range: assert property (activeStation >= fbfr_pkg::STATION_MIN
        && activeStation <= fbfr_pkg::STATION_MAX && activeLinkSpeed <= fbfr_pkg::SPEED_MAX)
        else $error("active link setting out of range");
    chk_option_code: assert property (optionContactFail [*2]
        |-> faultCode == fbfr_pkg::FAULT_OPTION)
        else $error("option fault code missing");
    chk_exchange_stop: assert property (faultCode == fbfr_pkg::FAULT_LINE && commLineError
        |-> !dataExchangeEnable)
        else $error("data exchange kept during line fault");
    chk_led_quiet: assert property ((activeStation == stationNumberSelect
        && activeLinkSpeed == linkSpeedSelect) [*4] |-> !linkErrorLed)
        else $error("link error indicator lit with settings applied");

    cov_error_reset: cover property (errorResetPulse);
    cov_drive_reset: cover property (driveResetPulse);
    cov_line_fault: cover property (faultCode == fbfr_pkg::FAULT_LINE);
endmodule

bind fbfr_control fbfr_control_chk u_chk (.*);

// File: test/fbfr_control_tb.sv
// Testbench for the fieldbus fault and reset control block
`timescale 1ns/1ps
module fbfr_control_tb;
    // ********************************
    // Signals
    // ********************************
    logic        mclk, rst_b, hwResetTerminal, modeChangeStrobe, commLineError;
    logic        optionContactFail, optionInternalFail, protectiveTrip, faultResetScopeSelect;
    logic        netErrorResetRequest, netDriveResetRequest, driveCommandValid;
    logic [1:0]  operationMode, stopModeOnCommError, activeMode;
    logic [7:0]  startupModeSelect, faultCode;
    logic [13:0] commErrorWaitTime;
    logic [6:0]  stationNumberSelect, activeStation;
    logic [2:0]  linkSpeedSelect, activeLinkSpeed;
    logic        dataExchangeEnable, tripCoast, tripDecel, faultOutput, driveResetPulse;
    logic        errorResetPulse, driveCommandAccept, settingInvalid, linkErrorLed;
    int          err_count, n_tests, errCnt, drvCnt, e0, d0;
    bit          ledSeen;
    // Rows: mode, scope, trip, expected error reset
    logic [4:0]  rows [7] = '{5'h03, 5'h0b, 5'h13, 5'h06, 5'h0f, 5'h16, 5'h08};

    fbfr_control #(.CMD_BLOCK_CYCLES(20), .WAIT_UNIT_CYCLES(4), .FLICKER_CYCLES(2)) uut (.*);
    fbfr_master_model mst (.*);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (errorResetPulse === 1'b1) errCnt++;
        if (driveResetPulse === 1'b1) drvCnt++;
    end

    // ********************************
    // Tasks
    // ********************************
    task chk(input logic ok);
        n_tests++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t check mismatch", $time);
        end
    endtask

    task setMode(input logic [1:0] m);
        @(posedge mclk);
        operationMode <= m;
        modeChangeStrobe <= 1'b1;
        @(posedge mclk);
        modeChangeStrobe <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task results();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        results();
    end

    // ********************************
    // Sequence
    // ********************************
    initial begin
        {rst_b, hwResetTerminal, modeChangeStrobe, commLineError} = 4'h0;
        {optionContactFail, optionInternalFail, protectiveTrip, faultResetScopeSelect} = 4'h0;
        operationMode = 2'h0;
        stopModeOnCommError = fbfr_pkg::STOP_COAST;
        startupModeSelect = 8'h00;
        commErrorWaitTime = 14'h0002;
        stationNumberSelect = 7'h01;
        linkSpeedSelect = 3'h0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(activeMode === 2'h0 && activeStation === 7'h01 && activeLinkSpeed === 3'h0);
        foreach (rows[i]) begin
            setMode(rows[i][4:3]);
            faultResetScopeSelect <= rows[i][2];
            protectiveTrip <= rows[i][1];
            e0 = errCnt;
            mst.errReset();
            repeat (3) @(posedge mclk);
            chk(errCnt - e0 === int'(rows[i][0]));
        end
        protectiveTrip <= 1'b0;
        setMode(fbfr_pkg::FBFR_MODE_EXT);
        d0 = drvCnt;
        mst.drvReset(2);
        repeat (3) @(posedge mclk);
        chk(drvCnt === d0);
        setMode(fbfr_pkg::FBFR_MODE_NET);
        mst.drvReset(2);
        repeat (3) @(posedge mclk);
        chk(drvCnt === d0 + 1 && activeMode === fbfr_pkg::FBFR_MODE_EXT);
        startupModeSelect <= 8'h01;
        setMode(fbfr_pkg::FBFR_MODE_NET);
        mst.drvReset(4);
        repeat (3) @(posedge mclk);
        chk(drvCnt === d0 + 2 && activeMode === fbfr_pkg::FBFR_MODE_NET);
        chk(driveCommandAccept === 1'b0);
        repeat (30) @(posedge mclk);
        chk(driveCommandAccept === 1'b1);
        stationNumberSelect <= 7'h41;
        repeat (2) @(posedge mclk);
        chk(settingInvalid === 1'b1);
        stationNumberSelect <= 7'h40;
        linkSpeedSelect <= 3'h4;
        ledSeen = 1'b0;
        repeat (12) begin
            @(posedge mclk);
            ledSeen |= (linkErrorLed === 1'b1);
        end
        chk(ledSeen && activeStation === 7'h01 && activeLinkSpeed === 3'h0);
        commLineError <= 1'b1;
        protectiveTrip <= 1'b1;
        d0 = drvCnt;
        e0 = errCnt;
        mst.drvReset(1);
        mst.errReset();
        commLineError <= 1'b0;
        protectiveTrip <= 1'b0;
        repeat (14) @(posedge mclk);
        chk(drvCnt === d0 && errCnt === e0);
        chk(faultCode === fbfr_pkg::FAULT_NONE);
        commLineError <= 1'b1;
        repeat (16) @(posedge mclk);
        chk(faultCode === fbfr_pkg::FAULT_LINE && dataExchangeEnable === 1'b0);
        chk(tripCoast === 1'b1);
        commLineError <= 1'b0;
        hwResetTerminal <= 1'b1;
        repeat (2) @(posedge mclk);
        hwResetTerminal <= 1'b0;
        repeat (12) @(posedge mclk);
        chk(activeStation === 7'h40 && activeLinkSpeed === 3'h4 && linkErrorLed === 1'b0);
        chk(faultCode === fbfr_pkg::FAULT_NONE);
        optionContactFail <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(faultCode === fbfr_pkg::FAULT_OPTION);
        optionContactFail <= 1'b0;
        stopModeOnCommError <= fbfr_pkg::STOP_DECEL;
        optionInternalFail <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(tripDecel === 1'b1 && tripCoast === 1'b0 && faultOutput === 1'b1);
        chk(dataExchangeEnable === 1'b0 && faultCode === fbfr_pkg::FAULT_OPTION);
        optionInternalFail <= 1'b0;
        stopModeOnCommError <= fbfr_pkg::STOP_COAST;
        repeat (2) @(posedge mclk);
        chk(dataExchangeEnable === 1'b1 && faultCode === fbfr_pkg::FAULT_NONE);
        results();
    end
endmodule
